/* src/adc_pkg.sv */
// shared constants and types for the converter link ends
package adc_pkg;
	localparam int RESULT_W = 18;
	localparam logic [17:0] ABORT_CODE = 18'h3FC00;
	localparam logic [17:0] CODE_POS_FULL = 18'h1FFFF;
	localparam logic [17:0] CODE_MID = 18'h00000;
	localparam logic [17:0] CODE_MID_M1 = 18'h3FFFF;
	localparam logic [17:0] CODE_NEG_FULL = 18'h20000;
	localparam int SYS_CLK_PERIOD_NS = 4;
	localparam int CONV_TIME_NS = 1100;
	localparam int THROUGHPUT_KSPS = 600;
	// longest time, so rounded down
	localparam int CONV_CYCLES = CONV_TIME_NS / SYS_CLK_PERIOD_NS;
	localparam int CNT_W = $clog2(CONV_CYCLES + 1);
	localparam int BIT_W = 5;
	localparam logic [4:0] LAST_SHIFT = 5'h11;
	// synchroniser bit positions on the device side
	localparam int SB_CONVERT_START_N = 0;
	localparam int SB_CS = 1;
	localparam int SB_FS = 2;
	localparam int SB_SCLK = 3;
	localparam int SB_PD = 4;
	localparam int SYNC_W = 5;
	localparam logic [4:0] SYNC_RST = 5'h0F;
	// host timing defaults in system clocks
	localparam int ACQ_CYCLES_DEF = 140;
	localparam int GAP_CYCLES_DEF = 8;
	localparam int SCLK_HALF_DEF = 10;
	localparam int HCNT_W = 8;
	typedef enum logic [2:0] {ST_WAIT, ST_NAP, ST_SAMPLE, ST_CONVERT, ST_PDOWN} dev_state_e;
	typedef enum logic [2:0] {H_IDLE, H_SAMPLE, H_CONV_WAIT, H_CONV, H_GAP, H_READ, H_END,
		H_PUSH} host_state_e;
endpackage

/* src/adc_link_if.sv */
// pins between the converter and its serial host
`timescale 1ns/10ps
interface adc_link_if;
	logic convert_start_n;
	logic cs_n;
	logic frame_sync_in;
	logic sclk;
	logic power_down_in;
	logic sdo;
	logic busy;
	modport dev (
		input convert_start_n, cs_n, frame_sync_in, sclk, power_down_in,
		output sdo, busy
	);
	modport host (
		output convert_start_n, cs_n, frame_sync_in, sclk, power_down_in,
		input sdo, busy
	);
endinterface

/* src/adc_dev.sv */
// converter end: conversion sequencing and serial result readout
// Behaviour
// R1: convert fall during conversion aborts it
// R2: aborted conversion returns to wait state
// R3: aborted conversion reads back code 3FC00
// R4: readout runs independently of conversion control
// R5: read during conversion returns previous result
// R6: host holds frame sync high for SPI
// R7: SPI: MSB at CS fall, shift after fall
// R8: CS re-fall mid frame restarts from MSB
// R9: FS mode: MSB at FS rise, shift later
// R10: FS high at busy fall reloads new MSB
// R11: FS rise mid frame restarts the frame
// R12: internal conversion timer; SCLK only shifts data
// R13: 18-bit two's complement result codes
// R14: result swaps at busy fall; avoid reads
// R15: host stays quiet around conversion edges
// R16: conversion completes within 1.1 us
// R17: offers full power-down and nap states
// R18: qualified start follows convert start while CS low
// R19: busy high exactly while converting
// R20: convert start high, CS low begins sampling
// R21: qualified start low at end gives nap
// R22: power-down input holds device in reset
// R23: eighteen bits MSB first, then hold
`timescale 1ns/10ps
module adc_dev
	import adc_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// link to the host
	adc_link_if.dev link,
	// analog front end stand-in: code held at the sampling instant
	input wire logic [RESULT_W-1:0] i_sample_code,
	// status
	output logic o_napping,
	output logic o_powered_down,
	output logic o_aborted
);

	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;
	logic [SYNC_W-1:0] prev_ff;
	logic convert_start_n_s;
	logic cs_n_s;
	logic fs_s;
	logic pd_s;
	logic cs_fall;
	logic cs_rise;
	logic fs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic qualified_convert_start_n_ff;
	logic qual_prev_ff;
	logic qual_fall;
	dev_state_e state_ff;
	logic [CNT_W-1:0] conv_cnt_ff;
	logic [RESULT_W-1:0] code_ff;
	logic [RESULT_W-1:0] result_ff;
	logic busy_ff;
	logic eoc;
	logic abort;
	logic sample_go;
	logic frame_start;
	logic reload;
	logic [RESULT_W-1:0] load_val;
	logic [RESULT_W-1:0] sr_ff;
	logic active_ff;
	logic seen_fall_ff;
	logic fs_mode_ff;
	logic [BIT_W-1:0] left_ff;

	// pins are asynchronous to this clock
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			sync1_ff <= SYNC_RST;
			sync2_ff <= SYNC_RST;
			prev_ff <= SYNC_RST;
		end else begin
			sync1_ff <= {link.power_down_in, link.sclk, link.frame_sync_in, link.cs_n,
				link.convert_start_n};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	assign convert_start_n_s = sync2_ff[SB_CONVERT_START_N];
	assign cs_n_s = sync2_ff[SB_CS];
	assign fs_s = sync2_ff[SB_FS];
	assign pd_s = sync2_ff[SB_PD];
	assign cs_fall = prev_ff[SB_CS] & ~cs_n_s;
	assign cs_rise = ~prev_ff[SB_CS] & cs_n_s;
	assign fs_rise = ~prev_ff[SB_FS] & fs_s & ~cs_n_s;
	// serial clock counts only while selected
	assign sclk_rise = ~prev_ff[SB_SCLK] & sync2_ff[SB_SCLK] & ~cs_n_s;
	assign sclk_fall = prev_ff[SB_SCLK] & ~sync2_ff[SB_SCLK] & ~cs_n_s;

	// latched only while selected, so a deselected host cannot start anything
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || pd_s) begin
			qualified_convert_start_n_ff <= 1'b1;
			qual_prev_ff <= 1'b1;
		end else begin
			if (!cs_n_s)
				qualified_convert_start_n_ff <= convert_start_n_s; // R18
			qual_prev_ff <= qualified_convert_start_n_ff;
		end
	end

	assign qual_fall = qual_prev_ff & ~qualified_convert_start_n_ff;
	assign sample_go = convert_start_n_s & ~cs_n_s; // R20
	assign abort = (state_ff == ST_CONVERT) && qual_fall; // R1
	// timer runs on the system clock, never on the serial clock
	assign eoc = (state_ff == ST_CONVERT) && !qual_fall &&
		(conv_cnt_ff == CNT_W'(CONV_CYCLES - 1)); // R12 R16

	// conversion sequencing
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			state_ff <= ST_WAIT;
		end else if (pd_s) begin
			state_ff <= ST_PDOWN; // R22 R17
		end else begin
			case (state_ff)
				ST_WAIT, ST_NAP: begin
					if (sample_go)
						state_ff <= ST_SAMPLE; // R20
				end
				ST_SAMPLE: begin
					if (qual_fall)
						state_ff <= ST_CONVERT;
				end
				ST_CONVERT: begin
					if (abort)
						state_ff <= ST_WAIT; // R2
					else if (eoc && sample_go)
						state_ff <= ST_SAMPLE; // R20
					else if (eoc && !qualified_convert_start_n_ff)
						state_ff <= ST_NAP; // R21 R17
					else if (eoc)
						state_ff <= ST_WAIT;
				end
				ST_PDOWN: begin
					state_ff <= ST_WAIT;
				end
				default: begin
					state_ff <= ST_WAIT;
				end
			endcase
		end
	end

	// conversion timer and sampled code
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || pd_s) begin
			conv_cnt_ff <= '0;
			code_ff <= CODE_MID;
		end else if (state_ff == ST_SAMPLE && qual_fall) begin
			conv_cnt_ff <= '0;
			code_ff <= i_sample_code; // R13
		end else if (state_ff == ST_CONVERT) begin
			conv_cnt_ff <= conv_cnt_ff + CNT_W'(1);
		end
	end

	// held result swaps only at the busy fall, so a read in conversion sees the old one
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || pd_s) begin
			result_ff <= CODE_MID;
			o_aborted <= 1'b0;
		end else if (abort) begin
			result_ff <= ABORT_CODE; // R3
			o_aborted <= 1'b1;
		end else if (eoc) begin
			result_ff <= code_ff; // R5 R14
			o_aborted <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || pd_s)
			busy_ff <= 1'b0;
		else if (state_ff == ST_SAMPLE && qual_fall)
			busy_ff <= 1'b1; // R19
		else if (eoc || abort)
			busy_ff <= 1'b0; // R19
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_napping <= 1'b0;
			o_powered_down <= 1'b0;
		end else begin
			o_napping <= (state_ff == ST_NAP);
			o_powered_down <= pd_s;
		end
	end

	// readout, driven by select, frame sync and serial clock, plus the busy fall reload in FS mode
	assign frame_start = (cs_fall && fs_s) || fs_rise; // R4 R8 R11
	assign reload = eoc && fs_s && fs_mode_ff && !cs_n_s; // R10
	// a frame started on the busy fall at eoc takes the new code, not the stale one
	assign load_val = eoc ? code_ff : result_ff;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || pd_s) begin
			sr_ff <= '0;
			active_ff <= 1'b0;
			seen_fall_ff <= 1'b0;
			fs_mode_ff <= 1'b0;
			left_ff <= '0;
		end else if (frame_start || reload) begin
			sr_ff <= load_val; // R7 R9
			active_ff <= 1'b1;
			seen_fall_ff <= 1'b0;
			left_ff <= LAST_SHIFT; // R23
			if (frame_start)
				fs_mode_ff <= fs_rise;
		end else if (active_ff) begin
			if (cs_rise && !fs_mode_ff)
				active_ff <= 1'b0;
			if (sclk_fall && (!fs_mode_ff || !fs_s))
				seen_fall_ff <= 1'b1; // R7 R9
			if (sclk_rise && seen_fall_ff && left_ff != '0) begin
				sr_ff <= {sr_ff[RESULT_W-2:0], 1'b0}; // R23
				left_ff <= left_ff - BIT_W'(1);
			end
		end
	end

	assign link.sdo = sr_ff[RESULT_W-1];
	assign link.busy = busy_ff;

endmodule

/* src/adc_host.sv */
// host end: starts conversions and shifts results into a small buffer
`timescale 1ns/10ps
module adc_host
	import adc_pkg::*;
#(
	parameter int WORD_W = RESULT_W,
	parameter int ACQ_CYCLES = ACQ_CYCLES_DEF,
	parameter int GAP_CYCLES = GAP_CYCLES_DEF,
	parameter int SCLK_HALF = SCLK_HALF_DEF
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// link to the converter
	adc_link_if.host link,
	// commands
	input wire logic i_start,
	input wire logic i_use_fs,
	input wire logic i_power_down,
	output logic o_start_ready,
	// result stream
	output logic [WORD_W-1:0] o_word,
	output logic o_word_valid,
	input wire logic i_word_ready
);

	logic sdo_m_ff;
	logic sdo_s_ff;
	logic busy_m_ff;
	logic busy_s_ff;
	host_state_e st_ff;
	logic [HCNT_W-1:0] cnt_ff;
	logic [BIT_W-1:0] bit_ff;
	logic use_fs_ff;
	logic cs_ff;
	logic convert_start_n_ff;
	logic fs_ff;
	logic sclk_ff;
	logic pd_ff;
	logic [WORD_W-1:0] word_ff;
	logic [WORD_W-1:0] tail_ff;
	logic [1:0] fill_ff;
	logic push;
	logic pop;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			sdo_m_ff <= 1'b0;
			sdo_s_ff <= 1'b0;
			busy_m_ff <= 1'b0;
			busy_s_ff <= 1'b0;
		end else begin
			sdo_m_ff <= link.sdo;
			sdo_s_ff <= sdo_m_ff;
			busy_m_ff <= link.busy;
			busy_s_ff <= busy_m_ff;
		end
	end

	assign push = (st_ff == H_PUSH) && (fill_ff != 2'h2);
	assign pop = o_word_valid && i_word_ready;

	// one conversion then one read; reads wait for the busy fall, keeping quiet zones
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			st_ff <= H_IDLE;
			cnt_ff <= '0;
			bit_ff <= '0;
			use_fs_ff <= 1'b0;
			cs_ff <= 1'b1;
			convert_start_n_ff <= 1'b1;
			fs_ff <= 1'b1;
			sclk_ff <= 1'b1;
			o_start_ready <= 1'b0;
			word_ff <= '0;
		end else begin
			case (st_ff)
				H_IDLE: begin
					cs_ff <= 1'b1;
					convert_start_n_ff <= 1'b1;
					sclk_ff <= 1'b1;
					fs_ff <= !i_use_fs; // R6
					o_start_ready <= !pd_ff;
					if (i_start && o_start_ready && !pd_ff) begin
						use_fs_ff <= i_use_fs;
						cs_ff <= 1'b0;
						cnt_ff <= '0;
						o_start_ready <= 1'b0;
						st_ff <= H_SAMPLE;
					end
				end
				H_SAMPLE: begin
					cnt_ff <= cnt_ff + HCNT_W'(1);
					if (cnt_ff == HCNT_W'(ACQ_CYCLES - 1)) begin
						convert_start_n_ff <= 1'b0;
						st_ff <= H_CONV_WAIT;
					end
				end
				// a single start fall per cycle, so no conversion is aborted by accident
				H_CONV_WAIT: begin
					if (busy_s_ff)
						st_ff <= H_CONV; // R1
				end
				H_CONV: begin
					if (!busy_s_ff) begin
						convert_start_n_ff <= 1'b1;
						cs_ff <= use_fs_ff ? 1'b0 : 1'b1;
						cnt_ff <= '0;
						st_ff <= H_GAP; // R15
					end
				end
				H_GAP: begin
					cnt_ff <= cnt_ff + HCNT_W'(1);
					// frame opens clear of the busy fall
					if (cnt_ff == HCNT_W'(GAP_CYCLES - 1)) begin
						if (use_fs_ff)
							fs_ff <= 1'b1;
						else
							cs_ff <= 1'b0; // R14
						cnt_ff <= '0;
						bit_ff <= '0;
						st_ff <= H_READ;
					end
				end
				H_READ: begin
					cnt_ff <= cnt_ff + HCNT_W'(1);
					if (use_fs_ff && bit_ff == '0 && cnt_ff == HCNT_W'(SCLK_HALF / 2))
						fs_ff <= 1'b0;
					if (cnt_ff == HCNT_W'(SCLK_HALF - 1)) begin
						word_ff <= {word_ff[WORD_W-2:0], sdo_s_ff};
						sclk_ff <= 1'b0;
						if (bit_ff == LAST_SHIFT)
							st_ff <= H_END;
					end
					if (cnt_ff == HCNT_W'(2 * SCLK_HALF - 1)) begin
						sclk_ff <= 1'b1;
						bit_ff <= bit_ff + BIT_W'(1);
						cnt_ff <= '0;
					end
				end
				H_END: begin
					sclk_ff <= 1'b1;
					cs_ff <= 1'b1;
					fs_ff <= !use_fs_ff;
					st_ff <= H_PUSH;
				end
				H_PUSH: begin
					// a full buffer stalls the next conversion here
					if (push)
						st_ff <= H_IDLE;
				end
				default: begin
					st_ff <= H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn)
			pd_ff <= 1'b0;
		else
			pd_ff <= i_power_down;
	end

	// two-entry buffer; head is the output register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_word <= '0;
			tail_ff <= '0;
			fill_ff <= 2'h0;
			o_word_valid <= 1'b0;
		end else begin
			if (push && pop) begin
				if (fill_ff == 2'h2) begin
					o_word <= tail_ff;
					tail_ff <= word_ff;
				end else begin
					o_word <= word_ff;
				end
			end else if (push) begin
				if (fill_ff == 2'h0)
					o_word <= word_ff;
				else
					tail_ff <= word_ff;
				fill_ff <= fill_ff + 2'h1;
				o_word_valid <= 1'b1;
			end else if (pop) begin
				o_word <= tail_ff;
				fill_ff <= fill_ff - 2'h1;
				o_word_valid <= (fill_ff == 2'h2);
			end
		end
	end

	assign link.cs_n = cs_ff;
	assign link.convert_start_n = convert_start_n_ff;
	assign link.frame_sync_in = fs_ff;
	assign link.sclk = sclk_ff;
	assign link.power_down_in = pd_ff;

endmodule

/* bench/adc_link_asserts.sv */
// pin checks on the link between host and converter ends
`timescale 1ns/10ps
module adc_link_asserts
	import adc_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// link pins
	input wire logic convert_start_n,
	input wire logic cs_n,
	input wire logic frame_sync_in,
	input wire logic sclk,
	input wire logic power_down_in,
	input wire logic sdo,
	input wire logic busy
);
	localparam int BUSY_MAX = CONV_CYCLES + 1;
	localparam int BUSY_MIN = CONV_CYCLES - 1;
	logic [9:0] busy_cnt_ff;
	logic [3:0] since_ff;
	logic [4:0] pins_ff;
	logic pin_event;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	// length of the current busy run
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || !busy) begin
			busy_cnt_ff <= 10'h000;
		end else begin
			busy_cnt_ff <= busy_cnt_ff + 10'h001;
		end
	end

	// pins one cycle back, reset to the host's idle levels
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			pins_ff <= 5'h1C;
		end else begin
			pins_ff <= {sclk, cs_n, frame_sync_in, busy, power_down_in};
		end
	end

	assign pin_event = (sclk & !pins_ff[4]) | (!cs_n & pins_ff[3]) | (frame_sync_in & !pins_ff[2])
		| (!busy & pins_ff[1]) | (power_down_in ^ pins_ff[0]);

	// saturating age of the last edge; covers the two-flop sync delay
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || pin_event) begin
			since_ff <= 4'h0;
		end else if (since_ff != 4'hF) begin
			since_ff <= since_ff + 4'h1;
		end
	end

	sequence s_conv_cmd;
		!cs_n && $fell(convert_start_n);
	endsequence

	sequence s_busy_up;
		$rose(busy);
	endsequence

	a_conv_starts: assert property (s_conv_cmd |-> ##[2:8] busy)
		else $error("busy missing after convert start");
	a_busy_cause: assert property (s_busy_up |-> !cs_n && $past(convert_start_n, 3) == 1'b0)
		else $error("busy rose without qualified start");
	a_busy_hold: assert property (s_busy_up |-> busy[*8])
		else $error("busy pulse too short");
	a_busy_max: assert property (busy_cnt_ff <= BUSY_MAX)
		else $error("conversion too long");
	a_busy_full: assert property ($fell(busy) |-> busy_cnt_ff >= BUSY_MIN)
		else $error("conversion ended early");
	a_busy_gap: assert property ($fell(busy) |-> !busy[*8])
		else $error("busy returned without a new start");
	a_sdo_on_edge: assert property ($changed(sdo) |-> pin_event || since_ff <= 4'h6)
		else $error("sdo moved without a link edge");
	a_pd_quiet: assert property (power_down_in[*7] |-> !busy && !sdo)
		else $error("activity during power down");
endmodule

/* bench/testbench.sv */
// host and converter joined, plus a second converter driven directly
`timescale 1ns/10ps
module testbench
	import adc_pkg::*;
;
	logic i_sys_clk;
	logic i_rstn;
	logic start, use_fs, power_down, word_ready;
	logic start_ready, word_valid, napping, powered_down, aborted;
	logic napping2, powered_down2, aborted2;
	logic [17:0] sample_code, code2, word, v;
	logic [17:0] codes [4];
	int fails, samples_checked;

	adc_link_if lnk();
	adc_link_if lnk_b();

	adc_host adc_host_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .link(lnk), .i_start(start),
		.i_use_fs(use_fs), .i_power_down(power_down), .o_start_ready(start_ready),
		.o_word(word), .o_word_valid(word_valid), .i_word_ready(word_ready));
	adc_dev adc_dev_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .link(lnk),
		.i_sample_code(sample_code), .o_napping(napping), .o_powered_down(powered_down),
		.o_aborted(aborted));
	adc_dev adc_dev_b_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .link(lnk_b),
		.i_sample_code(code2), .o_napping(napping2), .o_powered_down(powered_down2),
		.o_aborted(aborted2));
	adc_link_asserts adc_link_asserts_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
		.convert_start_n(lnk.convert_start_n), .cs_n(lnk.cs_n),
		.frame_sync_in(lnk.frame_sync_in), .sclk(lnk.sclk),
		.power_down_in(lnk.power_down_in), .sdo(lnk.sdo), .busy(lnk.busy));

	initial begin
		i_sys_clk = 1'b0;
		forever #2 i_sys_clk = ~i_sys_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic chk_word(input string name, input logic [17:0] exp, input logic [17:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// 0 word valid, 1 start ready, 2 second converter idle
	task automatic wait_for(input int which, input int limit);
		int n = 0;
		while (n < limit && !(which == 0 ? word_valid === 1'b1 : which == 1 ?
			start_ready === 1'b1 : lnk_b.busy === 1'b0)) begin
			tick(1);
			n++;
		end
		if (n >= limit) begin
			fails++;
			$display("ERROR wait %0d expected done seen timeout", which);
			report_and_stop();
		end
	endtask

	task automatic host_conv(input logic [17:0] code, input logic fs);
		wait_for(1, 3000);
		sample_code = code;
		use_fs = fs;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(1);
	endtask

	task automatic pop(input logic [17:0] exp);
		wait_for(0, 3000);
		chk_word("word", exp, word);
		word_ready = 1'b1;
		tick(1);
		word_ready = 1'b0;
		tick(1);
	endtask

	// cs raised before convert so the qualifier keeps its low value
	task automatic conv2(input logic [17:0] code);
		code2 = code;
		lnk_b.cs_n = 1'b0;
		lnk_b.convert_start_n = 1'b1;
		tick(10);
		lnk_b.convert_start_n = 1'b0;
		tick(10);
		lnk_b.cs_n = 1'b1;
		tick(2);
		lnk_b.convert_start_n = 1'b1;
		tick(4);
	endtask

	// bit sampled late in the low phase, after the synced shift lands
	task automatic rd(input logic fs, input int n, output logic [17:0] val);
		val = 18'h00000;
		if (fs) begin
			lnk_b.frame_sync_in = 1'b0;
			tick(4);
			lnk_b.frame_sync_in = 1'b1;
			tick(4);
			lnk_b.frame_sync_in = 1'b0;
		end else begin
			lnk_b.cs_n = 1'b0;
		end
		tick(4);
		for (int i = 0; i < n; i++) begin
			lnk_b.sclk = 1'b0;
			tick(4);
			val = {val[16:0], lnk_b.sdo};
			lnk_b.sclk = 1'b1;
			tick(4);
		end
		if (!fs) begin
			lnk_b.cs_n = 1'b1;
			tick(8);
		end
	endtask

	initial begin
		i_rstn = 1'b0;
		start = 1'b0;
		use_fs = 1'b0;
		power_down = 1'b0;
		word_ready = 1'b0;
		sample_code = 18'h00000;
		code2 = 18'h00000;
		fails = 0;
		samples_checked = 0;
		lnk_b.convert_start_n = 1'b1;
		lnk_b.cs_n = 1'b1;
		lnk_b.frame_sync_in = 1'b1;
		lnk_b.sclk = 1'b1;
		lnk_b.power_down_in = 1'b0;
		codes = '{CODE_POS_FULL, CODE_MID, CODE_MID_M1, CODE_NEG_FULL};
		tick(12);
		i_rstn = 1'b1;
		tick(2);
		for (int i = 0; i < 8; i++) begin
			host_conv(codes[i % 4], i > 3);
			pop(codes[i % 4]);
		end
		$display("test codes done");
		for (int i = 0; i < 3; i++) begin
			host_conv(codes[i], 1'b0);
		end
		tick(1500);
		chk_bit("start_ready", 1'b0, start_ready);
		for (int i = 0; i < 3; i++) begin
			pop(codes[i]);
		end
		$display("test buffer done");
		power_down = 1'b1;
		tick(12);
		chk_bit("powered_down", 1'b1, powered_down);
		chk_bit("start_ready", 1'b0, start_ready);
		power_down = 1'b0;
		tick(12);
		host_conv(CODE_MID_M1, 1'b1);
		pop(CODE_MID_M1);
		$display("test power down done");
		conv2(CODE_MID_M1);
		wait_for(2, 400);
		tick(2);
		chk_bit("napping", 1'b1, napping2);
		rd(1'b0, 18, v);
		chk_word("spi read", CODE_MID_M1, v);
		conv2(CODE_NEG_FULL);
		rd(1'b0, 18, v);
		chk_word("read busy", CODE_MID_M1, v);
		wait_for(2, 400);
		rd(1'b0, 5, v);
		chk_word("part read", {13'h0, CODE_NEG_FULL[17:13]}, v);
		rd(1'b0, 18, v);
		chk_word("restart", CODE_NEG_FULL, v);
		conv2(CODE_POS_FULL);
		lnk_b.cs_n = 1'b0;
		tick(6);
		lnk_b.convert_start_n = 1'b0;
		tick(8);
		chk_bit("busy", 1'b0, lnk_b.busy);
		tick(20);
		chk_bit("busy", 1'b0, lnk_b.busy);
		chk_bit("napping", 1'b0, napping2);
		chk_bit("aborted", 1'b1, aborted2);
		lnk_b.cs_n = 1'b1;
		tick(4);
		rd(1'b0, 18, v);
		chk_word("abort code", ABORT_CODE, v);
		lnk_b.convert_start_n = 1'b1;
		tick(6);
		lnk_b.convert_start_n = 1'b0;
		tick(20);
		chk_bit("busy", 1'b0, lnk_b.busy);
		code2 = CODE_POS_FULL;
		lnk_b.frame_sync_in = 1'b0;
		lnk_b.cs_n = 1'b0;
		lnk_b.convert_start_n = 1'b1;
		tick(10);
		lnk_b.frame_sync_in = 1'b1;
		tick(4);
		lnk_b.convert_start_n = 1'b0;
		tick(10);
		wait_for(2, 400);
		tick(6);
		chk_bit("sdo reload", CODE_POS_FULL[17], lnk_b.sdo);
		rd(1'b1, 6, v);
		chk_word("fs part", {12'h0, CODE_POS_FULL[17:12]}, v);
		rd(1'b1, 18, v);
		chk_word("fs restart", CODE_POS_FULL, v);
		$display("test direct converter done");
		report_and_stop();
	end
endmodule
